/* File: rtl/ldto_pkg.sv */
// Behaviour
// RULE1 - Four stacked layers, six frame sources
// RULE2 - Each frame fetched from its own address
// RULE3 - Two hardware cursors besides layer frames
// RULE4 - Right windows shown only when split
// RULE5 - Horizontal total, sync position, width, active
// RULE6 - Vertical total, sync position, width, active
// RULE7 - Software writes timing counts minus one
// RULE8 - Vertical sync width written minus one
// RULE9 - Boundary splits line into left, right
// RULE10 - Single frame: boundary equals active period
// RULE11 - Layer height written minus one
// RULE12 - Mode word packs color, flip, width, height; code decodes no flip bit
// RULE13 - Clear top bit means indirect color
// RULE14 - Width unit covers sixty-four bytes
// RULE15 - Origin, display address and position registers
// RULE16 - Top layer palette of 256 entries
// RULE17 - Transparent code register per layer
// RULE18 - Top layer composited over all others
// RULE19 - Blend select one mixes top layer
// RULE20 - Ratio 0x80 gives equal mix
// RULE21 - Blend only top pixels with alpha set
// RULE22 - Counters wrap, syncs and active windows
// RULE23 - Fetch address advances width per raster
`default_nettype none
package ldto_pkg;
	// ******************************
	// Structure
	// ******************************
	localparam int NUM_LAYERS   = 6;
	localparam int LAY_TOP      = 0;
	localparam int LAY_WIN      = 1;
	localparam int LAY_ML       = 2;
	localparam int LAY_MR       = 3;
	localparam int LAY_BL       = 4;
	localparam int LAY_BR       = 5;
	localparam int PIX_DIV      = 8;
	localparam int CAP_DELAY    = 2;
	localparam int LINE_UNIT    = 64;
	localparam int CURSOR_SIZE  = 64;
	localparam int CUR_COLOR_IX = 1;
	// ******************************
	// Register byte offsets, region codes and layer field indices
	// ******************************
	localparam logic [11:0] OFS_HTOTAL = 12'h000;
	localparam logic [11:0] OFS_HACT   = 12'h004;
	localparam logic [11:0] OFS_HBOUND = 12'h008;
	localparam logic [11:0] OFS_HSPOS  = 12'h00c;
	localparam logic [11:0] OFS_HSWID  = 12'h010;
	localparam logic [11:0] OFS_VTOTAL = 12'h014;
	localparam logic [11:0] OFS_VACT   = 12'h018;
	localparam logic [11:0] OFS_VSPOS  = 12'h01c;
	localparam logic [11:0] OFS_VSWID  = 12'h020;
	localparam logic [11:0] OFS_CTRL   = 12'h024;
	localparam logic [11:0] OFS_BSEL   = 12'h028;
	localparam logic [11:0] OFS_OVERLAY_BLEND_RATIO = 12'h02c;
	localparam logic [11:0] OFS_STATUS = 12'h030;
	localparam logic [11:0] OFS_CUR0   = 12'h034;
	localparam logic [11:0] OFS_CUR1   = 12'h038;
	localparam logic [3:0]  LAY_REGION = 4'h1;
	localparam logic [1:0]  PAL_REGION = 2'h1;
	localparam logic [2:0]  FLD_MODE   = 3'h0;
	localparam logic [2:0]  FLD_ORIG   = 3'h1;
	localparam logic [2:0]  FLD_DISP   = 3'h2;
	localparam logic [2:0]  FLD_POS    = 3'h3;
	localparam logic [2:0]  FLD_TRANSP = 3'h4;
	// ******************************
	// Field positions
	// ******************************
	localparam int MODE_DIRECT  = 31;
	localparam int MODE_W_MSB   = 23;
	localparam int MODE_W_LSB   = 16;
	localparam int MODE_H_MSB   = 15;
	localparam int TRANSP_EN    = 15;
	localparam int ALPHA_BIT    = 15;
	localparam int CTRL_SEP     = 8;
	localparam int CTRL_CUR0    = 9;
	localparam int CTRL_CUR1    = 10;
	// ******************************
	// Reset values and the blend weight of one
	// ******************************
	localparam logic [15:0] RST_HTOTAL = 16'h031f;
	localparam logic [15:0] RST_HACT   = 16'h027f;
	localparam logic [15:0] RST_HBOUND = 16'h027f;
	localparam logic [15:0] RST_HSPOS  = 16'h028f;
	localparam logic [7:0]  RST_HSWID  = 8'h5f;
	localparam logic [15:0] RST_VTOTAL = 16'h020c;
	localparam logic [15:0] RST_VACT   = 16'h01df;
	localparam logic [15:0] RST_VSPOS  = 16'h01e9;
	localparam logic [7:0]  RST_VSWID  = 8'h01;
	localparam logic [8:0]  BLEND_ONE  = 9'h100;
endpackage : ldto_pkg
`default_nettype wire

/* File: rtl/ldto_core.sv */
// Added by the designer: register access over Wishbone and the address map.
`default_nettype none
module ldto_core #(
	parameter int MEM_AW = 24,
	parameter int PAL_N  = 256
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [11:0]       wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Graphics memory read port
	output logic                   mem_rd,
	output logic      [MEM_AW-1:0] mem_addr,
	input  wire logic [15:0]       mem_rdata,
	// Video output
	output logic                   hsync,
	output logic                   vsync,
	output logic                   de,
	output logic      [15:0]       pixel
);
	// ******************************
	// Register file
	// ******************************
	logic [15:0] htotal_r, hact_r, hbound_r, hspos_r;
	logic [15:0] vtotal_r, vact_r, vspos_r;
	logic [7:0]  hswid_r, vswid_r;
	logic [15:0] ctrl_r, bsel_r, overlay_blend_ratio_r;
	logic [31:0] cur_r [2];
	localparam int NUM_LAYERS_C = ldto_pkg::NUM_LAYERS;
	logic [31:0] mode_r [NUM_LAYERS_C];
	logic [31:0] orig_r [NUM_LAYERS_C];
	logic [31:0] disp_r [NUM_LAYERS_C];
	logic [31:0] pos_r  [NUM_LAYERS_C];
	logic [15:0] transp_r [NUM_LAYERS_C];
	logic [15:0] pal_r [PAL_N];
	logic [15:0] h_r, v_r;
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		return m;
	endfunction : wmerge
	logic        wb_req, wb_wr, lay_hit, pal_hit;
	logic [2:0]  wl, wf;
	logic [7:0]  wp;
	logic [31:0] rd_val;
	assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr   = wb_req && wb_we_i;
	assign wl      = wb_adr_i[7:5];
	assign wf      = wb_adr_i[4:2];
	assign wp      = wb_adr_i[9:2];
	assign lay_hit = (wb_adr_i[11:8] == ldto_pkg::LAY_REGION)
		&& (int'(wl) < NUM_LAYERS_C);
	assign pal_hit = (wb_adr_i[11:10] == ldto_pkg::PAL_REGION)
		&& (int'(wp) < PAL_N);
	// Single-cycle answer, unmapped reads return zero
	always_ff @(posedge clock) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req) begin
				wb_dat_o <= rd_val;
			end
		end
	end
	always_comb begin
		rd_val = 32'h0000_0000;
		if (lay_hit) begin
			case (wf)
				ldto_pkg::FLD_MODE:   rd_val = mode_r[wl];
				ldto_pkg::FLD_ORIG:   rd_val = orig_r[wl];
				ldto_pkg::FLD_DISP:   rd_val = disp_r[wl];
				ldto_pkg::FLD_POS:    rd_val = pos_r[wl];
				ldto_pkg::FLD_TRANSP: rd_val = {16'h0000, transp_r[wl]};
				default:              rd_val = 32'h0000_0000;
			endcase
		end else if (pal_hit) begin
			rd_val = {16'h0000, pal_r[wp]};
		end else begin
			case (wb_adr_i)
				ldto_pkg::OFS_HTOTAL: rd_val = {16'h0000, htotal_r};
				ldto_pkg::OFS_HACT:   rd_val = {16'h0000, hact_r};
				ldto_pkg::OFS_HBOUND: rd_val = {16'h0000, hbound_r};
				ldto_pkg::OFS_HSPOS:  rd_val = {16'h0000, hspos_r};
				ldto_pkg::OFS_HSWID:  rd_val = {24'h000000, hswid_r};
				ldto_pkg::OFS_VTOTAL: rd_val = {16'h0000, vtotal_r};
				ldto_pkg::OFS_VACT:   rd_val = {16'h0000, vact_r};
				ldto_pkg::OFS_VSPOS:  rd_val = {16'h0000, vspos_r};
				ldto_pkg::OFS_VSWID:  rd_val = {24'h000000, vswid_r};
				ldto_pkg::OFS_CTRL:   rd_val = {16'h0000, ctrl_r};
				ldto_pkg::OFS_BSEL:   rd_val = {16'h0000, bsel_r};
				ldto_pkg::OFS_OVERLAY_BLEND_RATIO: rd_val = {16'h0000, overlay_blend_ratio_r};
				ldto_pkg::OFS_STATUS: rd_val = {v_r, h_r};
				ldto_pkg::OFS_CUR0:   rd_val = cur_r[0];
				ldto_pkg::OFS_CUR1:   rd_val = cur_r[1];
				default:              rd_val = 32'h0000_0000;
			endcase
		end
	end
	logic [31:0] wm;
	assign wm = wmerge(rd_val, wb_dat_i, wb_sel_i);
	// Global registers
	always_ff @(posedge clock) begin
		if (reset) begin
			htotal_r <= ldto_pkg::RST_HTOTAL;
			hact_r   <= ldto_pkg::RST_HACT;
			hbound_r <= ldto_pkg::RST_HBOUND;
			hspos_r  <= ldto_pkg::RST_HSPOS;
			hswid_r  <= ldto_pkg::RST_HSWID;
			vtotal_r <= ldto_pkg::RST_VTOTAL;
			vact_r   <= ldto_pkg::RST_VACT;
			vspos_r  <= ldto_pkg::RST_VSPOS;
			vswid_r  <= ldto_pkg::RST_VSWID;
			ctrl_r   <= 16'h0000;
			bsel_r   <= 16'h0000;
			overlay_blend_ratio_r <= 16'h0000;
			cur_r[0] <= 32'h0000_0000;
			cur_r[1] <= 32'h0000_0000;
		end else if (wb_wr && !lay_hit && !pal_hit) begin
			case (wb_adr_i)
				ldto_pkg::OFS_HTOTAL: htotal_r <= wm[15:0];
				ldto_pkg::OFS_HACT:   hact_r   <= wm[15:0];
				ldto_pkg::OFS_HBOUND: hbound_r <= wm[15:0];
				ldto_pkg::OFS_HSPOS:  hspos_r  <= wm[15:0];
				ldto_pkg::OFS_HSWID:  hswid_r  <= wm[7:0];
				ldto_pkg::OFS_VTOTAL: vtotal_r <= wm[15:0];
				ldto_pkg::OFS_VACT:   vact_r   <= wm[15:0];
				ldto_pkg::OFS_VSPOS:  vspos_r  <= wm[15:0];
				ldto_pkg::OFS_VSWID:  vswid_r  <= wm[7:0];
				ldto_pkg::OFS_CTRL:   ctrl_r   <= wm[15:0];
				ldto_pkg::OFS_BSEL:   bsel_r   <= wm[15:0];
				ldto_pkg::OFS_OVERLAY_BLEND_RATIO: overlay_blend_ratio_r <= wm[15:0];
				ldto_pkg::OFS_CUR0:   cur_r[0] <= wm;
				ldto_pkg::OFS_CUR1:   cur_r[1] <= wm;
				default:              ;
			endcase
		end
	end
	// Per-layer frame registers, six sources [RULE1] [RULE2] [RULE15]
	always_ff @(posedge clock) begin
		if (reset) begin
			for (int k = 0; k < NUM_LAYERS_C; k++) begin
				mode_r[k]   <= 32'h0000_0000;
				orig_r[k]   <= 32'h0000_0000;
				disp_r[k]   <= 32'h0000_0000;
				pos_r[k]    <= 32'h0000_0000;
				transp_r[k] <= 16'h0000;
			end
		end else if (wb_wr && lay_hit) begin
			case (wf)
				ldto_pkg::FLD_MODE:   mode_r[wl]   <= wm;
				ldto_pkg::FLD_ORIG:   orig_r[wl]   <= wm;
				ldto_pkg::FLD_DISP:   disp_r[wl]   <= wm;
				ldto_pkg::FLD_POS:    pos_r[wl]    <= wm;
				ldto_pkg::FLD_TRANSP: transp_r[wl] <= wm[15:0];
				default:              ;
			endcase
		end
	end
	// Palette, one entry per register [RULE16]
	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < PAL_N; i++) begin
				pal_r[i] <= 16'h0000;
			end
		end else if (wb_wr && pal_hit) begin
			pal_r[wp] <= wm[15:0];
		end
	end
	// ******************************
	// Timing generator
	// ******************************
	logic [2:0] slot_r;
	logic       pix_end;
	logic       h_act, v_act, hs_now, vs_now;
	assign pix_end = (slot_r == 3'(ldto_pkg::PIX_DIV - 1));
	always_ff @(posedge clock) begin
		if (reset) begin
			slot_r <= 3'h0;
		end else begin
			slot_r <= slot_r + 3'h1;
		end
	end
	// Counters wrap at programmed totals [RULE22] [RULE7]
	always_ff @(posedge clock) begin
		if (reset) begin
			h_r <= 16'h0000;
			v_r <= 16'h0000;
		end else if (pix_end) begin
			if (h_r >= htotal_r) begin
				h_r <= 16'h0000;
				v_r <= (v_r >= vtotal_r) ? 16'h0000 : v_r + 16'h0001;
			end else begin
				h_r <= h_r + 16'h0001;
			end
		end
	end
	assign h_act  = (h_r <= hact_r); // [RULE5] [RULE22]
	assign v_act  = (v_r <= vact_r); // [RULE6] [RULE22]
	assign hs_now = (h_r >= hspos_r)
		&& ((h_r - hspos_r) <= {8'h00, hswid_r}); // [RULE5]
	assign vs_now = (v_r >= vspos_r)
		&& ((v_r - vspos_r) <= {8'h00, vswid_r}); // [RULE6] [RULE8]
	// ******************************
	// Layer fetch
	// ******************************
	logic [31:0] f_mode;
	logic        f_direct, f_right, f_split, f_win, f_vis;
	logic [15:0] f_x;
	logic [31:0] f_addr;
	logic [2:0]  f_lay;
	assign f_lay    = slot_r;
	assign f_mode   = (int'(f_lay) < NUM_LAYERS_C) ? mode_r[f_lay]
		: 32'h0000_0000;
	assign f_direct = f_mode[ldto_pkg::MODE_DIRECT]; // [RULE12] [RULE13]
	assign f_right  = (f_lay == 3'(ldto_pkg::LAY_MR))
		|| (f_lay == 3'(ldto_pkg::LAY_BR));
	assign f_split  = (f_lay == 3'(ldto_pkg::LAY_ML))
		|| (f_lay == 3'(ldto_pkg::LAY_BL));
	// Right windows only in separation mode, past boundary [RULE4] [RULE9]
	assign f_win = f_right ? (ctrl_r[ldto_pkg::CTRL_SEP] && h_r > hbound_r)
		: f_split ? (!ctrl_r[ldto_pkg::CTRL_SEP] || h_r <= hbound_r)
		: 1'b1; // [RULE10]
	assign f_x   = f_right ? h_r - hbound_r - 16'h0001 : h_r;
	assign f_vis = (int'(f_lay) < NUM_LAYERS_C) && h_act && v_act
		&& ctrl_r[f_lay] && f_win
		&& (v_r <= f_mode[ldto_pkg::MODE_H_MSB:0]); // [RULE11] [RULE12]
	// Display address plus line stride [RULE14] [RULE15] [RULE23]
	assign f_addr = ((int'(f_lay) < NUM_LAYERS_C) ? disp_r[f_lay]
		: 32'h0000_0000)
		+ (f_direct ? {15'h0000, f_x, 1'b0} : {16'h0000, f_x})
		+ 32'(ldto_pkg::LINE_UNIT)
		* {24'h000000, f_mode[ldto_pkg::MODE_W_MSB:ldto_pkg::MODE_W_LSB]}
		* {16'h0000, v_r};
	logic        rd_d_r;
	logic [15:0] lay_pix_r [NUM_LAYERS_C];
	logic        lay_ok_r  [NUM_LAYERS_C];
	logic [2:0]  cap_lay;
	assign cap_lay = slot_r - 3'(ldto_pkg::CAP_DELAY);
	always_ff @(posedge clock) begin
		if (reset) begin
			mem_rd   <= 1'b0;
			mem_addr <= '0;
			rd_d_r   <= 1'b0;
		end else begin
			mem_rd   <= f_vis; // [RULE2]
			mem_addr <= f_addr[MEM_AW-1:0];
			rd_d_r   <= mem_rd;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int k = 0; k < NUM_LAYERS_C; k++) begin
				lay_pix_r[k] <= 16'h0000;
				lay_ok_r[k]  <= 1'b0;
			end
		end else if (slot_r >= 3'(ldto_pkg::CAP_DELAY)) begin
			lay_pix_r[cap_lay] <= mem_rdata;
			lay_ok_r[cap_lay]  <= rd_d_r;
		end
	end
	// ******************************
	// Compositing
	// ******************************
	function automatic logic [4:0] mix5(input logic [4:0] a,
		input logic [4:0] b, input logic [7:0] r);
		logic [14:0] s;
		s = 15'(a) * 15'(r)
			+ 15'(b) * (15'(ldto_pkg::BLEND_ONE) - 15'(r));
		return s[12:8];
	endfunction : mix5
	function automatic logic opaque(input logic ok, input logic [15:0] px,
		input logic [15:0] tc, input logic direct);
		logic hit;
		hit = direct ? (px[14:0] == tc[14:0]) : (px[7:0] == tc[7:0]);
		return ok && !(tc[ldto_pkg::TRANSP_EN] && hit);
	endfunction : opaque
	logic [15:0] pend_h_r, pend_v_r;
	logic        pend_hs_r, pend_vs_r, pend_de_r;
	logic [15:0] top_c, under, comp;
	logic        top_op, cur_hit;

	always_ff @(posedge clock) begin
		if (reset) begin
			pend_h_r  <= 16'h0000;
			pend_v_r  <= 16'h0000;
			pend_hs_r <= 1'b0;
			pend_vs_r <= 1'b0;
			pend_de_r <= 1'b0;
		end else if (pix_end) begin
			pend_h_r  <= h_r;
			pend_v_r  <= v_r;
			pend_hs_r <= hs_now;
			pend_vs_r <= vs_now;
			pend_de_r <= h_act && v_act;
		end
	end

	always_comb begin
		under = 16'h0000;
		for (int k = ldto_pkg::LAY_BR; k >= ldto_pkg::LAY_WIN; k--) begin
			if (opaque(lay_ok_r[k], lay_pix_r[k], transp_r[k],
				mode_r[k][ldto_pkg::MODE_DIRECT])) begin
				under = lay_pix_r[k]; // [RULE17]
			end
		end
	end

	// Top layer over all others, blended on alpha [RULE18]
	assign top_c  = pal_r[lay_pix_r[ldto_pkg::LAY_TOP][7:0]]; // [RULE16]
	assign top_op = opaque(lay_ok_r[ldto_pkg::LAY_TOP],
		lay_pix_r[ldto_pkg::LAY_TOP], transp_r[ldto_pkg::LAY_TOP],
		1'b0); // [RULE17]
	// Two box cursors in the palette cursor color [RULE3]
	function automatic logic in_cursor(input logic [31:0] c,
		input logic [15:0] x, input logic [15:0] y);
		return (x >= c[15:0]) && (x - c[15:0] < 16'(ldto_pkg::CURSOR_SIZE))
			&& (y >= c[31:16])
			&& (y - c[31:16] < 16'(ldto_pkg::CURSOR_SIZE));
	endfunction : in_cursor

	assign cur_hit =
		(ctrl_r[ldto_pkg::CTRL_CUR0] && in_cursor(cur_r[0], pend_h_r, pend_v_r))
		|| (ctrl_r[ldto_pkg::CTRL_CUR1]
		&& in_cursor(cur_r[1], pend_h_r, pend_v_r)); // [RULE3]

	always_comb begin
		comp = under;
		if (top_op) begin
			if (bsel_r[0] && top_c[ldto_pkg::ALPHA_BIT]) begin
				// [RULE19] [RULE20] [RULE21]
				comp = {1'b0,
					mix5(top_c[14:10], under[14:10], overlay_blend_ratio_r[7:0]),
					mix5(top_c[9:5], under[9:5], overlay_blend_ratio_r[7:0]),
					mix5(top_c[4:0], under[4:0], overlay_blend_ratio_r[7:0])};
			end else begin
				comp = top_c; // [RULE18]
			end
		end
		if (cur_hit) begin
			comp = pal_r[ldto_pkg::CUR_COLOR_IX];
		end
	end
	// Output stage, one pixel per period, blank outside display [RULE22]
	always_ff @(posedge clock) begin
		if (reset) begin
			hsync <= 1'b0;
			vsync <= 1'b0;
			de    <= 1'b0;
			pixel <= 16'h0000;
		end else if (slot_r == 3'h0) begin
			hsync <= pend_hs_r;
			vsync <= pend_vs_r;
			de    <= pend_de_r;
			pixel <= pend_de_r ? comp : 16'h0000;
		end
	end

	// ******************************
	// Checks
	// ******************************
	a_hcount_wrap: assert property (@(posedge clock) // [RULE22]
		disable iff (reset) pix_end && h_r >= htotal_r |=> h_r == 16'h0000)
		else $error("line counter did not wrap");
	a_hsync_start: assert property (@(posedge clock) // [RULE5]
		disable iff (reset) pix_end && h_r == hspos_r |-> ##2 hsync)
		else $error("hsync missing at position");
	a_vsync_width: assert property (@(posedge clock) // [RULE8]
		disable iff (reset) pix_end
		&& v_r == vspos_r + {8'h00, vswid_r} + 16'h0001
		&& v_r > vspos_r |-> ##2 !vsync)
		else $error("vsync too long");
	a_blank_black: assert property (@(posedge clock) // [RULE22]
		disable iff (reset) !de |-> pixel == 16'h0000)
		else $error("pixel outside display");
	a_right_hidden: assert property (@(posedge clock) // [RULE4]
		disable iff (reset) slot_r == 3'(ldto_pkg::LAY_MR)
		&& !ctrl_r[ldto_pkg::CTRL_SEP] |=> !mem_rd)
		else $error("right window fetched unsplit");
	a_height_stop: assert property (@(posedge clock) // [RULE11]
		disable iff (reset) int'(slot_r) < NUM_LAYERS_C
		&& v_r > f_mode[ldto_pkg::MODE_H_MSB:0] |=> !mem_rd)
		else $error("fetch past layer height");
	a_ack_single: assert property (@(posedge clock) disable iff (reset)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not one cycle");
	a_palette_write: assert property (@(posedge clock) // [RULE16]
		disable iff (reset) wb_wr && pal_hit && wb_sel_i == 4'hf
		|=> pal_r[$past(wp)] == $past(wb_dat_i[15:0]))
		else $error("palette entry not written");
endmodule : ldto_core
`default_nettype wire

/* File: tb/ldto_mem_model.sv */
`default_nettype none
module ldto_mem_model (
	// Clock
	input  wire logic        clock,
	// Graphics memory read port
	input  wire logic        mem_rd,
	input  wire logic [23:0] mem_addr,
	output logic      [15:0] mem_rdata,
	// Word returned for each 1 MiB region
	input  wire logic [15:0] region_word [8]
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] word_q = 16'ha5a5;
	assign mem_rdata = word_q;
	// *****************************
	// Read answer
	// *****************************
	// Valid only in the cycle after a request, scrambled otherwise
	always @(posedge clock) begin
		if (mem_rd) begin
			word_q <= region_word[mem_addr[22:20]];
		end else begin
			word_q <= ~word_q;
		end
	end
endmodule : ldto_mem_model
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// *****************************
	// Setup
	// *****************************
	localparam logic [15:0] HT = 16'h000f;
	localparam logic [15:0] HA = 16'h0009;
	localparam logic [15:0] HB = 16'h0004;
	localparam logic [15:0] HP = 16'h000b;
	localparam logic [15:0] VT = 16'h0009;
	localparam logic [15:0] VA = 16'h0005;
	localparam logic [15:0] VP = 16'h0007;
	localparam logic [7:0]  SW = 8'h01;
	localparam int          P  = ldto_pkg::PIX_DIV;
	localparam int          LN = (HT + 1) * P;
	localparam logic [15:0] C_BL = 16'h1234;
	localparam logic [15:0] C_BR = 16'h7c00;
	localparam logic [15:0] C_ML = 16'h0421;
	localparam logic [15:0] C_TP = 16'h2108;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        mem_rd;
	logic [23:0] mem_addr;
	logic [15:0] mem_rdata;
	logic        hsync;
	logic        vsync;
	logic        de;
	logic [15:0] pixel;
	logic [15:0] region_word [8] = '{16'h0003, 16'h03e0, C_ML, 16'h001f,
		C_BL, C_BR, 16'h0000, 16'h0000};
	int fails = 0;
	int n_checks = 0;
	always #2.5 clock = ~clock;
	ldto_core i_dut (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .hsync(hsync), .vsync(vsync), .de(de),
		.pixel(pixel));
	ldto_mem_model i_mem (.clock(clock), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.region_word(region_word));
	// *****************************
	// Shared tasks
	// *****************************
	task automatic end_of_test();
		if (fails == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_up();
		check(32'h0, 32'h1);
		end_of_test();
	endtask : give_up
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) give_up();
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask : wb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask : rd
	task automatic lay(input int l, input logic [2:0] f, input logic [31:0] d);
		wr(12'h100 + 12'(l * 32) + {7'h00, f, 2'b00}, d);
	endtask : lay
	function automatic logic sig(input int k);
		case (k)
			0: return hsync;
			1: return vsync;
			default: return de;
		endcase
	endfunction : sig
	task automatic wait_for(input int k, input logic v);
		int n;
		n = 0;
		while (sig(k) !== v) begin
			@(posedge clock);
			n++;
			if (n > 4 * LN * (VT + 1)) give_up();
		end
	endtask : wait_for
	task automatic gap(input int k, output int n);
		n = 0;
		while (sig(k) !== 1'b1 && n < 20000) begin
			n++;
			@(posedge clock);
		end
		if (n >= 20000) give_up();
	endtask : gap
	task automatic pulse(input int k, output int hi, output int per,
		output int des);
		logic pd;
		logic ps;
		wait_for(k, 1'b0);
		wait_for(k, 1'b1);
		hi = 0;
		per = 0;
		des = 0;
		pd = 1'b1;
		ps = 1'b1;
		while (!(sig(k) === 1'b1 && ps === 1'b0) && per < 20000) begin
			if (sig(k) === 1'b1) hi++;
			if (de === 1'b1 && pd === 1'b0) des++;
			pd = de;
			ps = sig(k);
			per++;
			@(posedge clock);
		end
		if (per >= 20000) give_up();
	endtask : pulse
	// Skips one whole line so that a new setting is in force
	task automatic px(input logic [15:0] e, input int n);
		int hit;
		int k;
		wait_for(2, 1'b1);
		wait_for(2, 1'b0);
		wait_for(2, 1'b1);
		hit = 0;
		k = 0;
		while (de === 1'b1 && k < LN) begin
			if (pixel === e) hit++;
			k++;
			@(posedge clock);
		end
		check(32'(hit), 32'(n));
	endtask : px
	// *****************************
	// Scenarios
	// *****************************
	task automatic t_regs();
		logic [31:0] v;
		logic [15:0] rv [9] = '{ldto_pkg::RST_HTOTAL, ldto_pkg::RST_HACT,
			ldto_pkg::RST_HBOUND, ldto_pkg::RST_HSPOS,
			{8'h00, ldto_pkg::RST_HSWID}, ldto_pkg::RST_VTOTAL,
			ldto_pkg::RST_VACT, ldto_pkg::RST_VSPOS,
			{8'h00, ldto_pkg::RST_VSWID}};
		// Timing registers sit at consecutive words from zero
		for (int i = 0; i < 9; i++) begin
			rd(12'(i * 4), v);
			check(v, {16'h0000, rv[i]});
		end
		wr(12'h03c, 32'hffff_ffff);
		rd(12'h03c, v);
		check(v, 32'h0);
	endtask : t_regs
	task automatic t_setup();
		logic [31:0] v;
		wr(ldto_pkg::OFS_HTOTAL, {16'h0, HT});
		wr(ldto_pkg::OFS_VTOTAL, {16'h0, VT});
		wr(ldto_pkg::OFS_HACT, {16'h0, HA});
		wr(ldto_pkg::OFS_HBOUND, {16'h0, HA});
		wr(ldto_pkg::OFS_HSPOS, {16'h0, HP});
		wr(ldto_pkg::OFS_HSWID, {24'h0, SW});
		wr(ldto_pkg::OFS_VACT, {16'h0, VA});
		wr(ldto_pkg::OFS_VSPOS, {16'h0, VP});
		wr(ldto_pkg::OFS_VSWID, {24'h0, SW});
		rd(ldto_pkg::OFS_HTOTAL, v);
		check(v, {16'h0, HT});
	endtask : t_setup
	task automatic t_timing();
		int hi;
		int per;
		int des;
		pulse(0, hi, per, des);
		check(32'(hi), 32'((SW + 1) * P));
		check(32'(per), 32'(LN));
		pulse(2, hi, per, des);
		check(32'(hi), 32'((HA + 1) * P));
		pulse(1, hi, per, des);
		check(32'(hi), 32'((SW + 1) * LN));
		check(32'(per), 32'((VT + 1) * LN));
		check(32'(des), 32'(VA + 1));
		wait_for(2, 1'b0);
		wait_for(2, 1'b1);
		gap(0, hi);
		check(32'(hi), 32'(HP * P));
		wait_for(1, 1'b1);
		wait_for(1, 1'b0);
		wait_for(2, 1'b1);
		gap(1, hi);
		check(32'(hi), 32'(VP * LN));
	endtask : t_timing
	task automatic t_layers();
		logic f0;
		logic f1;
		for (int l = 0; l < 6; l++) begin
			lay(l, ldto_pkg::FLD_MODE,
				(l == 0) ? 32'h0001_0005 : 32'h8002_0005);
			lay(l, ldto_pkg::FLD_DISP, 32'(l) << 20);
		end
		wr(ldto_pkg::OFS_CTRL, 32'h10);
		f0 = 1'b0;
		f1 = 1'b0;
		repeat (LN * (VT + 2)) begin
			@(posedge clock);
			if (mem_rd === 1'b1 && mem_addr === 24'h400000) f0 = 1'b1;
			if (mem_rd === 1'b1 && mem_addr === 24'h400292) f1 = 1'b1;
		end
		check({31'h0, f0}, 32'h1);
		check({31'h0, f1}, 32'h1);
		px(C_BL, (HA + 1) * P);
		wr(ldto_pkg::OFS_CTRL, 32'h14);
		px(C_ML, (HA + 1) * P);
		lay(ldto_pkg::LAY_ML, ldto_pkg::FLD_TRANSP, {16'h0, 16'h8000 | C_ML});
		px(C_BL, (HA + 1) * P);
		// Palette entry 3
		wr(12'h40c, {16'h0, C_TP});
		lay(ldto_pkg::LAY_TOP, ldto_pkg::FLD_TRANSP, 32'h8000);
		wr(ldto_pkg::OFS_CTRL, 32'h15);
		px(C_TP, (HA + 1) * P);
		region_word[0] <= 16'h0000;
		px(C_BL, (HA + 1) * P);
		region_word[0] <= 16'h0003;
		lay(ldto_pkg::LAY_ML, ldto_pkg::FLD_TRANSP, 32'h0);
		wr(12'h40c, {16'h0, 16'h8000 | C_TP});
		wr(ldto_pkg::OFS_BSEL, 32'h1);
		wr(ldto_pkg::OFS_OVERLAY_BLEND_RATIO, 32'h80);
		// Channels 8 and 1 mixed half and half give 4
		px(16'h1084, (HA + 1) * P);
		wr(12'h40c, {16'h0, C_TP});
		px(C_TP, (HA + 1) * P);
	endtask : t_layers
	task automatic t_split();
		wr(ldto_pkg::OFS_CTRL, 32'h38);
		wr(ldto_pkg::OFS_HBOUND, {16'h0, HB});
		px(C_BL, (HA + 1) * P);
		wr(ldto_pkg::OFS_CTRL, 32'h130);
		px(C_BR, (HA - HB) * P);
		px(C_BL, (HB + 1) * P);
		wr(ldto_pkg::OFS_HBOUND, {16'h0, HA});
		px(C_BL, (HA + 1) * P);
		// Cursor box at origin covers the whole active area
		wr(12'h404, {16'h0, 16'h03ff});
		wr(ldto_pkg::OFS_CUR0, 32'h0);
		wr(ldto_pkg::OFS_CTRL, 32'h230);
		px(16'h03ff, (HA + 1) * P);
	endtask : t_split
	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_regs();
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_setup();
		t_timing();
		t_layers();
		t_split();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
